// File: src/aicph_top.sv
// Audio input front end: clock selection, slave serial receiver, PDM capture and DC high-pass
`timescale 1ns/1ps
`include "aicph_defs.svh"
module aicph_top #(
	parameter int unsigned METER_WINDOW = `AICPH_METER_CYCLES
) (
	// System clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial audio link
	input wire logic bclk,
	input wire logic lrclk,
	input wire logic sdata,
	input wire logic mclk,
	// Straps and power
	input wire logic standalone_select,
	input wire logic address_or_input_select,
	input wire logic powerdown_n,
	// Register port
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Filtered audio
	output logic signed [23:0] sample_out,
	output logic sample_valid,
	// Clock generator control
	output aicph_pkg::aicph_clk_src_type clk_source,
	output logic [2:0] core_div,
	output logic dig_pll_source,
	output logic [3:0] dig_pll_exponent,
	output logic [7:0] apll_r,
	output logic [7:0] apll_n,
	output logic [7:0] apll_m,
	output logic [7:0] apll_x,
	output logic apll_enable,
	output logic apll_ref_ok
);
	import aicph_pkg::*;

	logic [7:0] master_clock_rate_config;
	logic [7:0] input_format_config;
	logic [7:0] serial_edge_config;
	logic [7:0] digital_pll_config;
	logic [7:0] analog_pll_param_a;
	logic [7:0] analog_pll_param_b;
	logic [7:0] analog_pll_param_c;
	logic [7:0] analog_pll_param_d;
	logic [7:0] analog_pll_param_e;
	logic [7:0] pll_route_control;
	logic [7:0] highpass_filter_control;

	// Divider from master clock to a 128x core clock
	function automatic logic [2:0] core_divider(input logic [2:0] mclk_rate_select);
		case (mclk_rate_select)
			3'h0: core_divider = 3'h1;
			3'h1: core_divider = 3'h1;
			3'h2: core_divider = 3'h2;
			3'h3: core_divider = 3'h3;
			3'h4: core_divider = 3'h4;
			3'h5: core_divider = 3'h6;
			default: core_divider = 3'h1;
		endcase
	endfunction

	// Filter gain in Q16: 3.7 Hz, or 50 Hz steps up to 750 Hz at 48 kHz
	function automatic logic [13:0] hpf_alpha(input logic app, input logic [3:0] hpf_corner_select);
		logic [3:0] steps;
		steps = (hpf_corner_select == 4'hF) ? 4'hF : hpf_corner_select + 4'h1;
		if (app) begin
			hpf_alpha = 14'(steps * `AICPH_ALPHA_STEP);
		end else begin
			hpf_alpha = `AICPH_ALPHA_AUDIO;
		end
	endfunction

	function automatic logic signed [23:0] sat24(input logic signed [25:0] v);
		if (v > 26'sh07FFFFF) begin
			sat24 = 24'sh7FFFFF;
		end else if (v < -26'sh0800000) begin
			sat24 = -24'sh800000;
		end else begin
			sat24 = v[23:0];
		end
	endfunction

	// Right-justified word is moved up to full scale by its length
	function automatic logic [23:0] rj_align(input logic [23:0] w, input logic [1:0] len);
		case (len)
			2'h0: rj_align = w;
			2'h1: rj_align = {w[19:0], 4'h0};
			2'h2: rj_align = {w[17:0], 6'h00};
			2'h3: rj_align = {w[15:0], 8'h00};
			default: rj_align = w;
		endcase
	endfunction

	// Register writes
	always_ff @(posedge clk) begin
		if (reset) begin
			master_clock_rate_config <= `AICPH_RST_MCLK_RATE;
			input_format_config <= `AICPH_RST_FORMAT;
			serial_edge_config <= `AICPH_RST_EDGE;
			digital_pll_config <= `AICPH_RST_DPLL;
			analog_pll_param_a <= `AICPH_RST_APLL_R;
			analog_pll_param_b <= `AICPH_RST_APLL_N;
			analog_pll_param_c <= `AICPH_RST_APLL_M;
			analog_pll_param_d <= `AICPH_RST_APLL_X;
			analog_pll_param_e <= `AICPH_RST_APLL_CTL;
			pll_route_control <= `AICPH_RST_ROUTE;
			highpass_filter_control <= `AICPH_RST_HPF;
		end else if (reg_write) begin
			case (reg_addr)
				`AICPH_ADDR_MCLK_RATE: master_clock_rate_config <= reg_wdata;
				`AICPH_ADDR_FORMAT: input_format_config <= reg_wdata;
				`AICPH_ADDR_EDGE: serial_edge_config <= reg_wdata;
				`AICPH_ADDR_DPLL: digital_pll_config <= reg_wdata;
				`AICPH_ADDR_APLL_R: analog_pll_param_a <= reg_wdata;
				`AICPH_ADDR_APLL_N: analog_pll_param_b <= reg_wdata;
				`AICPH_ADDR_APLL_M: analog_pll_param_c <= reg_wdata;
				`AICPH_ADDR_APLL_X: analog_pll_param_d <= reg_wdata;
				`AICPH_ADDR_APLL_CTL: analog_pll_param_e <= reg_wdata;
				`AICPH_ADDR_ROUTE: pll_route_control <= reg_wdata;
				`AICPH_ADDR_HPF: highpass_filter_control <= reg_wdata & `AICPH_HPF_MASK;
				default: ;
			endcase
		end
	end

	// Register reads, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
			case (reg_addr)
				`AICPH_ADDR_MCLK_RATE: reg_rdata <= master_clock_rate_config;
				`AICPH_ADDR_FORMAT: reg_rdata <= input_format_config;
				`AICPH_ADDR_EDGE: reg_rdata <= serial_edge_config;
				`AICPH_ADDR_DPLL: reg_rdata <= digital_pll_config;
				`AICPH_ADDR_APLL_R: reg_rdata <= analog_pll_param_a;
				`AICPH_ADDR_APLL_N: reg_rdata <= analog_pll_param_b;
				`AICPH_ADDR_APLL_M: reg_rdata <= analog_pll_param_c;
				`AICPH_ADDR_APLL_X: reg_rdata <= analog_pll_param_d;
				`AICPH_ADDR_APLL_CTL: reg_rdata <= {analog_pll_param_e[7:2], apll_ref_ok, analog_pll_param_e[0]};
				`AICPH_ADDR_ROUTE: reg_rdata <= pll_route_control;
				`AICPH_ADDR_HPF: reg_rdata <= highpass_filter_control;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Pin synchronisers into the system domain
	logic [1:0] sa_sync;
	logic [1:0] addr_sync;
	logic [1:0] mclk_sync;
	logic [1:0] pd_sync;
	logic [1:0] bclk_sync;
	always_ff @(posedge clk) begin
		if (reset) begin
			sa_sync <= 2'h0;
			addr_sync <= 2'h0;
			mclk_sync <= 2'h0;
			pd_sync <= 2'h0;
			bclk_sync <= 2'h0;
		end else begin
			sa_sync <= {sa_sync[0], standalone_select};
			addr_sync <= {addr_sync[0], address_or_input_select};
			mclk_sync <= {mclk_sync[0], mclk};
			pd_sync <= {pd_sync[0], powerdown_n};
			bclk_sync <= {bclk_sync[0], bclk};
		end
	end

	logic run;
	assign run = pd_sync[1];

	// Clock source and PLL settings
	always_ff @(posedge clk) begin
		if (reset) begin
			clk_source <= aicph_src_mclk;
			core_div <= 3'h1;
			dig_pll_source <= 1'b0;
			dig_pll_exponent <= `AICPH_DPLL_MIN_N;
			apll_r <= `AICPH_RST_APLL_R;
			apll_n <= `AICPH_RST_APLL_N;
			apll_m <= `AICPH_RST_APLL_M;
			apll_x <= `AICPH_RST_APLL_X;
		end else begin
			if (pll_route_control[`AICPH_BIT_ROUTE_EN]) begin
				clk_source <= pll_route_control[`AICPH_BIT_ROUTE_BCLK] ? aicph_src_bclk : aicph_src_pll; // RULE_04
			end else begin
				clk_source <= aicph_src_mclk; // RULE_02
			end
			core_div <= core_divider(master_clock_rate_config[2:0]); // RULE_05 RULE_06 RULE_01
			dig_pll_source <= digital_pll_config[4]; // RULE_09
			if (digital_pll_config[3:0] < `AICPH_DPLL_MIN_N) begin
				dig_pll_exponent <= `AICPH_DPLL_MIN_N; // RULE_07
			end else if (digital_pll_config[3:0] > `AICPH_DPLL_MAX_N) begin
				dig_pll_exponent <= `AICPH_DPLL_MAX_N; // RULE_07
			end else begin
				dig_pll_exponent <= digital_pll_config[3:0]; // RULE_09
			end
			apll_r <= analog_pll_param_a; // RULE_10
			apll_n <= analog_pll_param_b; // RULE_10
			apll_m <= (analog_pll_param_c == 8'h00) ? 8'h01 : analog_pll_param_c; // RULE_10
			apll_x <= (analog_pll_param_d == 8'h00) ? 8'h01 : analog_pll_param_d; // RULE_10
		end
	end

	// Reference meter: edges per window give the reference in kHz at the default window
	logic ref_prev;
	logic ref_now;
	logic [15:0] win_cnt;
	logic [15:0] edge_cnt;
	logic [31:0] apll_in_khz;
	assign ref_now = dig_pll_source ? bclk_sync[1] : mclk_sync[1];
	always_ff @(posedge clk) begin
		if (reset) begin
			ref_prev <= 1'b0;
			win_cnt <= 16'h0000;
			edge_cnt <= 16'h0000;
			apll_in_khz <= 32'h00000000;
		end else begin
			ref_prev <= ref_now;
			if (win_cnt == 16'(METER_WINDOW - 1)) begin
				win_cnt <= 16'h0000;
				edge_cnt <= 16'h0000;
				apll_in_khz <= {16'h0000, edge_cnt} << dig_pll_exponent; // RULE_07
			end else begin
				win_cnt <= win_cnt + 16'h0001;
				if (ref_now && !ref_prev) begin
					edge_cnt <= edge_cnt + 16'h0001;
				end
			end
		end
	end

	// Analog PLL runs only from an in-band reference
	always_ff @(posedge clk) begin
		if (reset) begin
			apll_ref_ok <= 1'b0;
			apll_enable <= 1'b0;
		end else begin
			apll_ref_ok <= (apll_in_khz >= `AICPH_APLL_MIN_KHZ) && (apll_in_khz <= `AICPH_APLL_MAX_KHZ); // RULE_08
			apll_enable <= analog_pll_param_e[`AICPH_BIT_APLL_EN] && apll_ref_ok && run; // RULE_08 RULE_22
		end
	end

	// Link configuration, held in flops so the crossing samples clean levels
	logic [6:0] cfg_src;
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_src <= 7'h00;
		end else begin
			cfg_src[6] <= sa_sync[1] ? addr_sync[1] : input_format_config[`AICPH_BIT_PDM]; // RULE_13
			cfg_src[5] <= sa_sync[1] ? mclk_sync[1] : serial_edge_config[`AICPH_BIT_EDGE_SWAP]; // RULE_15 RULE_16
			cfg_src[4:3] <= input_format_config[1:0];
			cfg_src[2:1] <= input_format_config[3:2];
			cfg_src[0] <= run; // RULE_22
		end
	end

	// Link domain: reset and configuration arrive through two flops each.
	// Configuration is quasi-static, so per-bit skew lasts one bit clock at most.
	logic [1:0] lrst_sync;
	logic [6:0] cfg_s1;
	logic [6:0] cfg_s2;
	logic link_reset;
	always_ff @(posedge bclk) begin
		lrst_sync <= {lrst_sync[0], reset};
		cfg_s1 <= cfg_src;
		cfg_s2 <= cfg_s1;
	end
	assign link_reset = lrst_sync[1] || !cfg_s2[0];

	logic density_input_select;
	logic edge_swap;
	aicph_format_type fmt;
	logic [1:0] word_len;
	assign density_input_select = cfg_s2[6];
	assign edge_swap = cfg_s2[5];
	assign fmt = aicph_format_type'(cfg_s2[4:3]);
	assign word_len = cfg_s2[2:1];

	// Falling-edge capture for PDM; read half a bit clock later on the rising edge
	logic fall_bit;
	always_ff @(negedge bclk) begin
		fall_bit <= sdata; // RULE_14
	end

	// Serial receiver: data and frame clock are sampled on bit clock rising edges
	logic lr_prev;
	logic [5:0] bit_cnt;
	logic [31:0] shreg;
	logic restart;
	logic [5:0] cur_pos;
	logic pcm_take;
	logic [23:0] pcm_word;
	assign restart = (fmt == aicph_fmt_tdm) ? (lrclk && !lr_prev) : (lrclk != lr_prev); // RULE_03
	assign cur_pos = restart ? 6'h00 : bit_cnt;

	always_comb begin
		pcm_take = 1'b0;
		pcm_word = {shreg[22:0], sdata};
		case (fmt)
			aicph_fmt_i2s: pcm_take = !lrclk && (cur_pos == 6'h18); // RULE_11
			aicph_fmt_left: pcm_take = lrclk && (cur_pos == 6'h17); // RULE_11
			aicph_fmt_tdm: pcm_take = cur_pos == 6'h18; // RULE_11
			aicph_fmt_right: begin
				pcm_take = restart && !lrclk; // RULE_11
				pcm_word = rj_align(shreg[23:0], word_len); // RULE_12
			end
			default: pcm_take = 1'b0;
		endcase
	end

	always_ff @(posedge bclk) begin
		if (link_reset) begin
			lr_prev <= 1'b0;
			bit_cnt <= 6'h00;
			shreg <= 32'h00000000;
		end else begin
			lr_prev <= lrclk;
			shreg <= {shreg[30:0], sdata};
			if (restart) begin
				bit_cnt <= 6'h01;
			end else if (bit_cnt != 6'h3F) begin
				bit_cnt <= bit_cnt + 6'h01;
			end
		end
	end

	// PDM decimation: ones over 64 bit clocks of the left channel make one sample
	logic pdm_bit;
	logic [5:0] pdm_cnt;
	logic [6:0] ones;
	logic [6:0] ones_next;
	assign pdm_bit = edge_swap ? fall_bit : sdata; // RULE_15 RULE_16
	assign ones_next = ones + {6'h00, pdm_bit};

	logic [23:0] link_word;
	logic link_toggle;
	always_ff @(posedge bclk) begin
		if (link_reset) begin
			pdm_cnt <= 6'h00;
			ones <= 7'h00;
			link_word <= 24'h000000;
			link_toggle <= 1'b0;
		end else if (density_input_select) begin
			pdm_cnt <= pdm_cnt + 6'h01;
			if (pdm_cnt == 6'h3F) begin
				ones <= 7'h00;
				link_word <= {ones_next - `AICPH_PDM_HALF, 17'h00000}; // RULE_14
				link_toggle <= !link_toggle;
			end else begin
				ones <= ones_next; // RULE_14
			end
		end else begin
			pdm_cnt <= 6'h00;
			ones <= 7'h00;
			if (pcm_take) begin
				link_word <= pcm_word; // RULE_11
				link_toggle <= !link_toggle;
			end
		end
	end

	// Word crossing: the toggle is synchronised, the word is stable long before it lands
	logic [2:0] tog_sync;
	logic word_event;
	always_ff @(posedge clk) begin
		if (reset) begin
			tog_sync <= 3'h0;
		end else begin
			tog_sync <= {tog_sync[1:0], link_toggle};
		end
	end
	assign word_event = tog_sync[2] ^ tog_sync[1];

	// High-pass: DC estimate tracks while enabled and stays frozen once disabled
	logic hpf_on;
	logic hpf_hold_and_mode;
	logic [3:0] hpf_corner_select;
	logic signed [39:0] dc_acc;
	logic signed [23:0] dc_est;
	logic signed [23:0] x_in;
	logic signed [24:0] diff;
	logic signed [14:0] alpha_s;
	logic signed [39:0] step;
	assign hpf_on = highpass_filter_control[`AICPH_BIT_HPF_ON];
	assign hpf_hold_and_mode = highpass_filter_control[`AICPH_BIT_HPF_HOLD];
	assign hpf_corner_select = highpass_filter_control[5:2];
	assign dc_est = dc_acc[39:16];
	assign x_in = link_word;
	assign diff = 25'(x_in) - 25'(dc_est);
	assign alpha_s = {1'b0, hpf_alpha(hpf_hold_and_mode, hpf_corner_select)}; // RULE_19 RULE_20 RULE_21
	assign step = 40'(diff) * 40'(alpha_s);

	always_ff @(posedge clk) begin
		if (reset) begin
			dc_acc <= 40'sh0000000000;
		end else if (word_event && run && hpf_on) begin
			dc_acc <= dc_acc + step; // RULE_17 RULE_21
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sample_out <= 24'sh000000;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= word_event && run;
			if (word_event && run) begin
				if (hpf_on || hpf_hold_and_mode) begin
					sample_out <= sat24(26'(x_in) - 26'(dc_est)); // RULE_17 RULE_18
				end else begin
					sample_out <= x_in; // RULE_23
				end
			end
		end
	end
endmodule

// File: src/aicph_defs.svh
// Constants for the audio input clocking, serial receiver and high-pass block
// Functional notes
// [RULE_01] Core clock stays within 5.6448 to 8.192 MHz, set by sample rate.
// [RULE_02] Master clock comes from the PLL, the bit clock pin or the master clock pin.
// [RULE_03] Far side supplies clocks synchronous with its serial audio data.
// [RULE_04] Route enable derives the master-rate clock from PLL or bit clock, no pin.
// [RULE_05] Master clock pin rate is the sample-rate multiple chosen by the rate field.
// [RULE_06] Core clock is an integer multiple of sample rate; other clocks derive from it.
// [RULE_07] Digital PLL multiplies 8 kHz to 8 MHz references by 2^N, N from 1 to 10.
// [RULE_08] Analog PLL accepts references only between 8 MHz and 27 MHz.
// [RULE_09] Digital PLL reference and multiplier come from the digital PLL register.
// [RULE_10] Analog PLL output is input times (R + N/M) divided by X.
// [RULE_11] Serial port is slave only: I2S, left, right justified, TDM or PDM.
// [RULE_12] Word length is used only in right-justified format.
// [RULE_13] Density_input_select: input select pin high in standalone, or format bit 7 under I2C.
// [RULE_14] PDM takes one-bit data on serial data, captured on each bit clock edge.
// [RULE_15] Standalone PDM: master clock pin low gives left on rising edge, high reverses.
// [RULE_16] I2C PDM: edge swap bit 0 gives left on rising edge, 1 on falling.
// [RULE_17] Enabled filter continuously estimates DC and subtracts it from samples.
// [RULE_18] Hold bit keeps last estimate subtracted after disable until hold is cleared.
// [RULE_19] Audio mode corner is fixed at 3.7 Hz for 48 kHz sampling.
// [RULE_20] Application mode corner is 50 to 750 Hz from the four-bit corner field.
// [RULE_21] Mode bit 0 selects audio, 1 application; filter runs only when enable is 1.
// [RULE_22] Far side may stop master clock in power-down but supplies it to operate.
// [RULE_23] Filter off and nothing held: samples pass through unchanged.
`ifndef AICPH_DEFS_SVH
`define AICPH_DEFS_SVH

`define AICPH_ADDR_MCLK_RATE 8'h00
`define AICPH_ADDR_FORMAT 8'h01
`define AICPH_ADDR_EDGE 8'h03
`define AICPH_ADDR_DPLL 8'h08
`define AICPH_ADDR_APLL_R 8'h09
`define AICPH_ADDR_APLL_N 8'h0A
`define AICPH_ADDR_APLL_M 8'h0B
`define AICPH_ADDR_APLL_X 8'h0C
`define AICPH_ADDR_APLL_CTL 8'h0D
`define AICPH_ADDR_ROUTE 8'h0E
`define AICPH_ADDR_HPF 8'h15

`define AICPH_RST_MCLK_RATE 8'h01
`define AICPH_RST_FORMAT 8'h00
`define AICPH_RST_EDGE 8'h00
`define AICPH_RST_DPLL 8'h01
`define AICPH_RST_APLL_R 8'h01
`define AICPH_RST_APLL_N 8'h00
`define AICPH_RST_APLL_M 8'h01
`define AICPH_RST_APLL_X 8'h01
`define AICPH_RST_APLL_CTL 8'h00
`define AICPH_RST_ROUTE 8'h00
`define AICPH_RST_HPF 8'h00

`define AICPH_BIT_PDM 7
`define AICPH_BIT_EDGE_SWAP 0
`define AICPH_BIT_ROUTE_EN 0
`define AICPH_BIT_ROUTE_BCLK 1
`define AICPH_BIT_APLL_EN 0
`define AICPH_BIT_HPF_ON 0
`define AICPH_BIT_HPF_HOLD 1
`define AICPH_HPF_MASK 8'h3F

`define AICPH_CLK_MHZ 50
`define AICPH_METER_US 1000
`define AICPH_METER_CYCLES (`AICPH_METER_US * `AICPH_CLK_MHZ)
`define AICPH_APLL_MIN_KHZ 32'd8000
`define AICPH_APLL_MAX_KHZ 32'd27000
`define AICPH_DPLL_MIN_N 4'h1
`define AICPH_DPLL_MAX_N 4'hA

`define AICPH_ALPHA_AUDIO 14'h0020
`define AICPH_ALPHA_STEP 14'h01AD
`define AICPH_PDM_HALF 7'h20

`endif

// File: src/aicph_pkg.sv
// Types shared by the audio input clocking and receiver block
package aicph_pkg;
	typedef enum logic [1:0] {
		aicph_src_mclk,
		aicph_src_pll,
		aicph_src_bclk
	} aicph_clk_src_type;

	typedef enum logic [1:0] {
		aicph_fmt_i2s,
		aicph_fmt_left,
		aicph_fmt_right,
		aicph_fmt_tdm
	} aicph_format_type;
endpackage

// File: sim/aicph_asserts.sv
// Concurrent checks on the ports of the audio input front end
`timescale 1ns/1ps
module aicph_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Straps and register port
	input wire logic powerdown_n,
	input wire logic standalone_select,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rvalid,
	// Audio and clock control
	input wire logic signed [23:0] sample_out,
	input wire logic sample_valid,
	input wire aicph_pkg::aicph_clk_src_type clk_source,
	input wire logic [2:0] core_div,
	input wire logic [3:0] dig_pll_exponent,
	input wire logic [7:0] apll_m,
	input wire logic [7:0] apll_x,
	input wire logic apll_enable,
	input wire logic apll_ref_ok
);
	import aicph_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Cycles spent in power-down; samples already in flight may still land early on
	logic [7:0] pd_cnt;
	always_ff @(posedge clk) begin
		if (reset || powerdown_n) begin
			pd_cnt <= 8'h00;
		end else if (pd_cnt != 8'hFF) begin
			pd_cnt <= pd_cnt + 8'h01;
		end
	end
	rd_answer_a: assert property (reg_read |=> reg_rvalid)
		else $error("read not answered");
	rd_cause_a: assert property (reg_rvalid |-> $past(reg_read))
		else $error("read answer without request");
	smp_pulse_a: assert property (sample_valid |=> !sample_valid)
		else $error("sample strobe longer than one cycle");
	smp_hold_a: assert property ($changed(sample_out) |-> sample_valid)
		else $error("sample changed without strobe");
	pd_quiet_a: assert property (pd_cnt >= 8'h28 |-> !sample_valid && !apll_enable)
		else $error("activity in power-down");
	apll_gate_a: assert property (apll_enable |-> apll_ref_ok)
		else $error("analog PLL on with reference out of band");
	exp_range_a: assert property (dig_pll_exponent >= 4'h1 && dig_pll_exponent <= 4'hA)
		else $error("digital PLL exponent out of range");
	div_legal_a: assert property (core_div inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6})
		else $error("core divider not a legal ratio");
	apll_ratio_a: assert property (apll_m != 8'h00 && apll_x != 8'h00)
		else $error("analog PLL divisor zero");
	route_off_a: assert property (reg_write && reg_addr == 8'h0E && !reg_wdata[0] && !standalone_select
		|-> ##[1:2] clk_source == aicph_src_mclk) else $error("route off did not select pin");
	cover property (sample_valid);
	cover property (reg_rvalid);
	cover property (clk_source == aicph_src_bclk);
endmodule

// File: sim/aicph_source_model.sv
// Serial audio source: free-running bit clock, frame clock and PCM or PDM data
`timescale 1ns/1ps
module aicph_source_model (
	// Link pins
	output logic bclk,
	output logic lrclk,
	output logic sdata,
	// Stream settings
	input wire logic pdm,
	input wire logic [1:0] fmt,
	input wire logic [23:0] word,
	input wire logic [6:0] ones
);
	logic [5:0] pos;
	int off;
	int start;
	initial begin
		bclk = 1'b0;
		lrclk = 1'b0;
		sdata = 1'b0;
		pos = 6'h00;
		#7;
		forever #32 bclk = ~bclk;
	end
	// Moves after the falling edge, past the PDM hold time of that edge
	always @(negedge bclk) begin
		#8;
		pos = pos + 6'h01;
		start = (fmt == 2'h2) ? 8 : (fmt == 2'h1 ? 0 : 1);
		off = int'(pos[4:0]) - start;
		lrclk = (fmt == 2'h0) ? pos[5] : (fmt == 2'h3 ? (pos == 6'h00) : !pos[5]);
		if (pdm) sdata = ({1'b0, pos} < ones);
		else if (off >= 0 && off < 24) sdata = word[23 - off] ^ pos[5];
		else sdata = pos[0];
	end
	// Other channel carries the complement, so a wrong edge choice shows
	always @(posedge bclk) begin
		if (pdm) begin
			#16;
			sdata = !({1'b0, pos} < ones);
		end
	end
endmodule

// File: sim/aicph_tb_top.sv
// Self-checking bench for the audio input front end
`timescale 1ns/1ps
module aicph_tb_top;
	import aicph_pkg::*;
	logic clk = 1'b0, reset = 1'b1, mclk = 1'b0, powerdown_n = 1'b1;
	logic standalone_select = 1'b0, address_or_input_select = 1'b0;
	logic reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic bclk, lrclk, sdata, reg_rvalid, sample_valid, dig_pll_source, apll_enable, apll_ref_ok;
	logic [7:0] reg_rdata, apll_r, apll_n, apll_m, apll_x;
	logic signed [23:0] sample_out;
	aicph_clk_src_type clk_source;
	logic [2:0] core_div;
	logic [3:0] dig_pll_exponent;
	logic m_pdm = 1'b0;
	logic [1:0] m_fmt = 2'h0;
	logic [23:0] m_word = 24'h000000;
	logic [6:0] m_ones = 7'h00;
	int n_errors = 0;
	int n_tests = 0;
	int seed = 71591;
	logic [7:0] addrs [11] = '{8'h00, 8'h01, 8'h03, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h15};
	logic [7:0] rsts [11] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	// Bit 1 of the analog PLL control reads back live status
	logic [7:0] masks [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFD, 8'hFF, 8'h3F};
	logic [3:0] pcm_cases [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hE, 4'hD};
	always #10 clk = ~clk;
	aicph_source_model u_aicph_source_model (.bclk(bclk), .lrclk(lrclk), .sdata(sdata), .pdm(m_pdm),
		.fmt(m_fmt), .word(m_word), .ones(m_ones));
	aicph_top #(.METER_WINDOW(64)) u_aicph_top (.clk(clk), .reset(reset), .bclk(bclk), .lrclk(lrclk),
		.sdata(sdata), .mclk(mclk), .standalone_select(standalone_select),
		.address_or_input_select(address_or_input_select), .powerdown_n(powerdown_n),
		.reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_out(sample_out), .sample_valid(sample_valid),
		.clk_source(clk_source), .core_div(core_div), .dig_pll_source(dig_pll_source),
		.dig_pll_exponent(dig_pll_exponent), .apll_r(apll_r), .apll_n(apll_n), .apll_m(apll_m),
		.apll_x(apll_x), .apll_enable(apll_enable), .apll_ref_ok(apll_ref_ok));
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge clk);
		#1;
		reg_write = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge clk);
		#1;
		reg_read = 1'b0;
		chk("read strobe", {23'h0, reg_rvalid}, 24'h1);
		d = reg_rdata;
	endtask
	task automatic next_smp(output logic signed [23:0] s);
		int k;
		k = 0;
		@(negedge clk);
		while (sample_valid !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 3000) chk("sample wait", 24'h0, 24'h1);
		s = sample_out;
		@(posedge clk);
		#1;
	endtask
	// First samples after a change may straddle the old setting
	task automatic settle_chk(input string what, input logic [23:0] exp);
		logic signed [23:0] s;
		repeat (4) next_smp(s);
		chk(what, s, exp);
	endtask
	function automatic logic [2:0] div_of(input logic [2:0] c);
		case (c)
			3'h2, 3'h3, 3'h4: return c;
			3'h5: return 3'h6;
			default: return 3'h1;
		endcase
	endfunction
	function automatic logic [23:0] pdm_of(input logic [6:0] n);
		return {n, 17'h0} - 24'h400000;
	endfunction
	function automatic logic [23:0] pcm_of(input logic [3:0] c, input logic [23:0] w);
		return (c == 4'hE) ? {w[15:0], 8'h00} : w;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		logic [7:0] d;
		logic [7:0] v;
		logic [31:0] r;
		logic [3:0] e;
		logic signed [23:0] s1, s2, x;
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
		for (int i = 0; i < 11; i++) begin
			rd(addrs[i], d);
			chk("reset value", {16'h0, d & masks[i]}, {16'h0, rsts[i] & masks[i]});
			v = 8'($random(seed));
			wr(addrs[i], v);
			rd(addrs[i], d);
			chk("readback", {16'h0, d & masks[i]}, {16'h0, v & masks[i]});
		end
		wr(8'h02, 8'hA5);
		rd(8'h02, d);
		chk("unmapped", {16'h0, d}, 24'h0);
		$display("registers done");
		for (int c = 0; c < 8; c++) begin
			wr(8'h00, 8'(c));
			chk("core_div", {21'h0, core_div}, {21'h0, div_of(3'(c))});
		end
		for (int n = 0; n < 16; n++) begin
			wr(8'h08, {3'h0, n[0], n[3:0]});
			e = (n == 0) ? 4'h1 : (n > 10 ? 4'hA : 4'(n));
			chk("pll exponent", {20'h0, dig_pll_exponent}, {20'h0, e});
			chk("pll source", {23'h0, dig_pll_source}, {23'h0, n[0]});
		end
		wr(8'h08, 8'h0A);
		for (int k = 0; k < 3; k++) begin
			r = (k == 0) ? 32'h0 : $random(seed);
			wr(8'h09, r[7:0]);
			wr(8'h0A, r[15:8]);
			wr(8'h0B, r[23:16]);
			wr(8'h0C, r[31:24]);
			chk("apll r", {16'h0, apll_r}, {16'h0, r[7:0]});
			chk("apll n", {16'h0, apll_n}, {16'h0, r[15:8]});
			chk("apll m", {16'h0, apll_m}, (r[23:16] == 8'h00) ? 24'h1 : {16'h0, r[23:16]});
			chk("apll x", {16'h0, apll_x}, (r[31:24] == 8'h00) ? 24'h1 : {16'h0, r[31:24]});
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h0E, 8'(i));
			chk("clk source", {22'h0, clk_source},
				{22'h0, i[0] ? (i[1] ? aicph_src_bclk : aicph_src_pll) : aicph_src_mclk});
		end
		$display("clock control done");
		wr(8'h15, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(8'h01, {4'h0, pcm_cases[i]});
			m_fmt = pcm_cases[i][1:0];
			m_word = (i == 0) ? 24'h800000 : 24'($random(seed));
			settle_chk("pcm sample", pcm_of(pcm_cases[i], m_word));
		end
		chk("apll ref", {23'h0, apll_ref_ok}, 24'h0);
		chk("apll off", {23'h0, apll_enable}, 24'h0);
		m_fmt = 2'h0;
		wr(8'h01, 8'h00);
		powerdown_n = 1'b0;
		repeat (100) @(posedge clk);
		#1;
		powerdown_n = 1'b1;
		settle_chk("after power-down", m_word);
		$display("pcm done");
		wr(8'h01, 8'h80);
		m_pdm = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (i < 2) wr(8'h03, 8'(i));
			if (i == 2) wr(8'h01, 8'h00);
			if (i >= 2) begin
				standalone_select = 1'b1;
				address_or_input_select = 1'b1;
				mclk = i[0];
			end
			m_ones = (i == 0) ? 7'h40 : 7'($random(seed) & 32'h3F);
			settle_chk("pdm sample", pdm_of(i[0] ? 7'h40 - m_ones : m_ones));
		end
		standalone_select = 1'b0;
		address_or_input_select = 1'b0;
		mclk = 1'b0;
		m_pdm = 1'b0;
		$display("pdm done");
		reset = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
		x = 24'h100000;
		m_word = x;
		settle_chk("hpf off", x);
		wr(8'h15, 8'h01);
		repeat (40) next_smp(s1);
		chk("hpf audio", {23'h0, (s1 < x) && (s1 > x - (x >>> 3))}, 24'h1);
		wr(8'h15, 8'h3F);
		repeat (40) next_smp(s1);
		chk("hpf application", {23'h0, s1 < (x >>> 2)}, 24'h1);
		wr(8'h15, 8'h02);
		repeat (4) next_smp(s1);
		m_word = 24'h080000;
		repeat (4) next_smp(s2);
		chk("held offset", x - s1, 24'h080000 - s2);
		chk("held applied", {23'h0, s1 != x}, 24'h1);
		wr(8'h15, 8'h00);
		settle_chk("hold released", 24'h080000);
		$display("hpf done");
		report_and_stop();
	end
endmodule
bind aicph_top aicph_asserts u_aicph_asserts (.clk(clk), .reset(reset), .powerdown_n(powerdown_n),
	.standalone_select(standalone_select), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .sample_out(sample_out), .sample_valid(sample_valid),
	.clk_source(clk_source), .core_div(core_div), .dig_pll_exponent(dig_pll_exponent), .apll_m(apll_m),
	.apll_x(apll_x), .apll_enable(apll_enable), .apll_ref_ok(apll_ref_ok));
